//--- core/adc_i2c_command_control.sv
// two-wire slave and command decoder of the eight-channel converter
`include "adc_defs.svh"
module adc_i2c_command_control (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    input  wire logic       I_ADDRESS_PIN_LOW,
    input  wire logic       I_ADDRESS_PIN_HIGH,
    input  wire logic       I_CMP,
    output logic            O_SDA_OE,
    output logic            O_SDA,
    output logic            O_SCL_OE,
    output logic            O_SCL,
    output logic            O_INPUT_TYPE_SELECT,
    output logic [2:0]      O_CHANNEL_SELECT_BITS,
    output logic [7:0]      O_POS_INPUT_SEL,
    output logic [7:0]      O_NEG_INPUT_SEL,
    output logic            O_NEG_IS_SHARED,
    output logic            O_REF_POWER_SELECT,
    output logic            O_CONVERTER_POWER_SELECT,
    output logic            O_CONVERTER_ON,
    output logic [7:0]      O_DAC_TRIAL,
    output logic            O_HS_MODE
);
    typedef struct packed {
        logic [1:0]          scl_s;
        logic [1:0]          sda_s;
        logic [1:0]          apin_m;
        logic [1:0]          apin_s;
        logic                full;
        logic                scl_d;
        logic                sda_d;
        adc_pkg::adc_state_t state;
        logic [2:0]          bit_cnt;
        logic [7:0]          shift;
        logic                first_byte;
        logic                is_read;
        logic                ack_me;
        logic                addr_done;
        logic [1:0]          addr_lo;
        logic [7:0]          command;
        logic                cmd_seen;
        logic                start_conv;
        logic                hs;
        logic                hs_pending;
        logic                sda_oe;
        logic                scl_oe;
        logic [7:0]          pos_sel;
        logic [7:0]          neg_sel;
        logic                neg_shared;
        logic                conv_on;
    } adc_st_t;
    adc_st_t st_reg;
    adc_st_t st_next;
    adc_sar_if sar_bus ();

    // one-hot decode of a three-bit input index, used for both mux legs
    function automatic logic [7:0] adc_onehot(input logic [2:0] idx);
        adc_onehot = 8'h01 << idx;
    endfunction

    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
    logic [2:0] ch;
    logic [2:0] ch_n;
    logic [2:0] idx_single;
    logic [2:0] idx_even;

    assign scl      = st_reg.scl_s[1];
    assign sda      = st_reg.sda_s[1];
    assign scl_rise = scl & ~st_reg.scl_d;
    assign scl_fall = ~scl & st_reg.scl_d;
    assign start_c  = scl & st_reg.scl_d & st_reg.sda_d & ~sda;
    assign stop_c   = scl & st_reg.scl_d & ~st_reg.sda_d & sda;
    assign ch         = st_reg.command[`ADC_CMD_CH_HI:`ADC_CMD_CH_LO];
    // legs follow the command being written, so they change with the type bit
    assign ch_n       = st_next.command[`ADC_CMD_CH_HI:`ADC_CMD_CH_LO];
    assign idx_single = {ch_n[1:0], ch_n[2]};
    assign idx_even   = {ch_n[1:0], 1'b0};

    always_comb begin
        st_next            = st_reg;
        st_next.scl_s      = {st_reg.scl_s[0], I_SCL};
        st_next.sda_s      = {st_reg.sda_s[0], I_SDA};
        st_next.apin_m     = {I_ADDRESS_PIN_HIGH, I_ADDRESS_PIN_LOW};
        st_next.apin_s     = st_reg.apin_m;
        st_next.scl_d      = scl;
        st_next.sda_d      = sda;
        st_next.start_conv = 1'b0;
        if (stop_c) begin
            st_next.state  = adc_pkg::ADC_IDLE;
            st_next.sda_oe = 1'b0;
            st_next.scl_oe = 1'b0;
            if (!st_reg.hs_pending) begin
                st_next.hs = 1'b0;
            end
        end else if (start_c) begin
            // repeated start keeps high-speed mode
            st_next.state      = adc_pkg::ADC_RECV;
            st_next.bit_cnt    = `ADC_BIT_FIRST;
            st_next.first_byte = 1'b1;
            st_next.full       = 1'b0;
            st_next.sda_oe     = 1'b0;
            st_next.cmd_seen   = 1'b0;
            if (st_reg.hs_pending) begin
                st_next.hs         = 1'b1;
                st_next.hs_pending = 1'b0;
            end
        end else begin
            case (st_reg.state)
                adc_pkg::ADC_IDLE: begin
                    st_next.sda_oe = 1'b0;
                end
                adc_pkg::ADC_RECV: begin
                    if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], sda};
                        // address pins caught at the eighth rise of the first transaction
                        if (st_reg.first_byte && st_reg.bit_cnt == `ADC_BIT_LAST && !st_reg.addr_done) begin
                            st_next.addr_lo   = st_reg.apin_s;
                            st_next.addr_done = 1'b1;
                        end
                        if (!st_reg.first_byte && st_reg.bit_cnt == 3'h3) begin
                            st_next.command[7:4] = {st_reg.shift[2:0], sda};
                            st_next.cmd_seen     = 1'b1;
                            st_next.start_conv   = 1'b1;
                        end
                        if (st_reg.bit_cnt == `ADC_BIT_LAST) begin
                            st_next.full = 1'b1;
                        end
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                    end
                    // full guards against the clock fall that follows a start
                    if (scl_fall && st_reg.bit_cnt == `ADC_BIT_FIRST && st_reg.full) begin
                        // eight bits in; the ninth pulse is the acknowledge
                        st_next.full = 1'b0;
                        if (st_reg.first_byte) begin
                            st_next.is_read = st_reg.shift[0];
                            st_next.ack_me  = st_reg.shift[7:1] ==
                                {`ADC_ADDR_FIXED, st_reg.addr_done ? st_reg.addr_lo : st_reg.apin_s};
                            if (st_reg.shift[7:3] == `ADC_HS_CODE) begin
                                st_next.hs_pending = 1'b1;
                            end
                        end else begin
                            st_next.command = st_reg.shift;
                            st_next.ack_me  = 1'b1;
                        end
                        if (st_next.ack_me) begin
                            st_next.sda_oe = 1'b1;
                            st_next.state  = adc_pkg::ADC_ACK;
                        end else begin
                            st_next.state  = adc_pkg::ADC_IDLE;
                        end
                    end
                end
                adc_pkg::ADC_ACK: begin
                    if (scl_fall) begin
                        st_next.sda_oe     = 1'b0;
                        st_next.first_byte = 1'b0;
                        st_next.bit_cnt    = `ADC_BIT_FIRST;
                        if (st_reg.is_read) begin
                            // hold the clock low while a conversion runs in high-speed mode
                            if (st_reg.hs && sar_bus.busy) begin
                                st_next.scl_oe = 1'b1;
                                st_next.state  = adc_pkg::ADC_WAIT;
                            end else begin
                                st_next.sda_oe = ~sar_bus.result[7];
                                st_next.state  = adc_pkg::ADC_SEND;
                            end
                        end else begin
                            st_next.state = adc_pkg::ADC_RECV;
                        end
                    end
                end
                adc_pkg::ADC_WAIT: begin
                    if (!sar_bus.busy) begin
                        st_next.scl_oe = 1'b0;
                        st_next.sda_oe = ~sar_bus.result[7];
                        st_next.state  = adc_pkg::ADC_SEND;
                    end
                end
                adc_pkg::ADC_SEND: begin
                    if (scl_fall) begin
                        if (st_reg.bit_cnt == `ADC_BIT_LAST) begin
                            st_next.sda_oe = 1'b0;
                            st_next.state  = adc_pkg::ADC_MACK;
                        end else begin
                            st_next.sda_oe = ~sar_bus.result[3'h6 - st_reg.bit_cnt];
                        end
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                    end
                end
                adc_pkg::ADC_MACK: begin
                    if (scl_rise) begin
                        // a no-acknowledge ends the read; the master then stops
                        if (sda) begin
                            st_next.state = adc_pkg::ADC_IDLE;
                        end
                    end else if (scl_fall) begin
                        st_next.bit_cnt = `ADC_BIT_FIRST;
                        st_next.sda_oe  = ~sar_bus.result[7];
                        st_next.state   = adc_pkg::ADC_SEND;
                    end
                end
                default: begin
                    st_next.state = adc_pkg::ADC_IDLE;
                end
            endcase
        end
        if (st_next.command[`ADC_CMD_SD_BIT]) begin
            st_next.pos_sel    = adc_onehot(idx_single);
            st_next.neg_sel    = `ADC_ZERO8;
            st_next.neg_shared = 1'b1;
        end else begin
            st_next.pos_sel    = adc_onehot(idx_even + {2'b00, ch_n[2]});
            st_next.neg_sel    = adc_onehot(idx_even + {2'b00, ~ch_n[2]});
            st_next.neg_shared = 1'b0;
        end
        // converter runs only while converting, from a start until the slave falls back to idle, or when held on by mode
        st_next.conv_on = sar_bus.busy || st_reg.start_conv || (st_reg.state != adc_pkg::ADC_IDLE) ||
            st_reg.command[`ADC_CMD_PD_LO];
    end

    assign sar_bus.start = st_reg.start_conv;
    assign sar_bus.cmp   = I_CMP;

    adc_sar u_sar (
        .i_clk (I_SYS_CLK),
        .i_rst (I_SYS_RST),
        .sar   (sar_bus)
    );

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            st_reg         <= '0;
            st_reg.scl_s   <= 2'b11;
            st_reg.sda_s   <= 2'b11;
            st_reg.scl_d   <= 1'b1;
            st_reg.sda_d   <= 1'b1;
            st_reg.state   <= adc_pkg::ADC_IDLE;
            st_reg.command <= `ADC_CMD_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_SDA_OE                 = st_reg.sda_oe;
    assign O_SDA                    = 1'b0;
    assign O_SCL_OE                 = st_reg.scl_oe;
    assign O_SCL                    = 1'b0;
    assign O_INPUT_TYPE_SELECT      = st_reg.command[`ADC_CMD_SD_BIT];
    assign O_CHANNEL_SELECT_BITS    = ch;
    assign O_POS_INPUT_SEL          = st_reg.pos_sel;
    assign O_NEG_INPUT_SEL          = st_reg.neg_sel;
    assign O_NEG_IS_SHARED          = st_reg.neg_shared;
    assign O_REF_POWER_SELECT       = st_reg.command[`ADC_CMD_PD_HI];
    assign O_CONVERTER_POWER_SELECT = st_reg.command[`ADC_CMD_PD_LO];
    assign O_CONVERTER_ON           = st_reg.conv_on;
    assign O_DAC_TRIAL              = sar_bus.trial;
    assign O_HS_MODE                = st_reg.hs;
endmodule

//--- core/adc_defs.svh
// constants for the two-wire converter command block
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define ADC_ADDR_FIXED   5'b1_0010
`define ADC_HS_CODE      5'b0_0001
`define ADC_CMD_SD_BIT   7
`define ADC_CMD_CH_HI    6
`define ADC_CMD_CH_LO    4
`define ADC_CMD_PD_HI    3
`define ADC_CMD_PD_LO    2
`define ADC_CMD_RESET    8'h00
`define ADC_BIT_LAST     3'h7
`define ADC_BIT_FIRST    3'h0
`define ADC_SAR_STEPS    4'h8
`define ADC_SAR_DONE     4'h0
`define ADC_PD_BOTH_OFF  2'h0
`define ADC_PD_CONV_ON   2'h1
`define ADC_PD_REF_ON    2'h2
`define ADC_PD_BOTH_ON   2'h3
`define ADC_SAR_MSB      8'h80
`define ADC_ZERO8        8'h00
`endif

//--- core/adc_pkg.sv
// types shared by the converter command block
package adc_pkg;
    typedef enum logic [5:0] {
        ADC_IDLE  = 6'b00_0001,
        ADC_RECV  = 6'b00_0010,
        ADC_ACK   = 6'b00_0100,
        ADC_SEND  = 6'b00_1000,
        ADC_MACK  = 6'b01_0000,
        ADC_WAIT  = 6'b10_0000
    } adc_state_t;
endpackage

//--- core/adc_sar_if.sv
// handshake between the serial front end and the approximation sequencer
interface adc_sar_if;
    logic       start;
    logic       busy;
    logic       cmp;
    logic [7:0] trial;
    logic [7:0] result;
    modport ctl (output start, input busy, input result);
    modport sar (input start, output busy, output result, output trial, input cmp);
endinterface

//--- core/adc_sar.sv
// successive approximation sequencer, one bit per step
`include "adc_defs.svh"
module adc_sar (
    input  wire logic i_clk,
    input  wire logic i_rst,
    adc_sar_if.sar    sar
);
    typedef struct packed {
        logic [3:0] steps;
        logic [7:0] mask;
        logic [7:0] value;
        logic [7:0] result;
        logic [7:0] trial;
    } adc_sar_st_t;
    adc_sar_st_t st_reg;
    adc_sar_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (sar.start) begin
            st_next.steps = `ADC_SAR_STEPS;
            st_next.mask  = `ADC_SAR_MSB;
            st_next.value = `ADC_ZERO8;
        end else if (st_reg.steps != `ADC_SAR_DONE) begin
            // keep the trial bit only when the comparator says input is above it
            if (sar.cmp) begin
                st_next.value = st_reg.value | st_reg.mask;
            end
            st_next.mask  = st_reg.mask >> 1;
            st_next.steps = st_reg.steps - 4'h1;
            if (st_reg.steps == 4'h1) begin
                st_next.result = sar.cmp ? (st_reg.value | st_reg.mask) : st_reg.value;
            end
        end
        // trial is registered so the comparator always judges the word on the pins
        st_next.trial = st_next.value | st_next.mask;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '{steps: `ADC_SAR_DONE, mask: `ADC_ZERO8, value: `ADC_ZERO8, result: `ADC_ZERO8,
                        trial: `ADC_ZERO8};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sar.busy   = st_reg.steps != `ADC_SAR_DONE;
    assign sar.trial  = st_reg.trial;
    assign sar.result = st_reg.result;
endmodule

//--- dv/adc_chk.sv
// assertion checker for the two-wire converter command block
module adc_chk (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_SCL,
    input  wire logic       O_SDA_OE,
    input  wire logic       O_SCL_OE,
    input  wire logic       O_INPUT_TYPE_SELECT,
    input  wire logic [7:0] O_POS_INPUT_SEL,
    input  wire logic [7:0] O_NEG_INPUT_SEL,
    input  wire logic       O_REF_POWER_SELECT,
    input  wire logic       O_CONVERTER_ON,
    input  wire logic [7:0] O_DAC_TRIAL,
    input  wire logic       O_HS_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    wire [7:0] legs = O_POS_INPUT_SEL | O_NEG_INPUT_SEL;
    // drive reacts three cycles after the pin, whose sampled value shows one edge late
    sequence s_ack_stands;
        O_SDA_OE [*5];
    endsequence
    sequence s_stretch_ends;
        ##[1:60] !O_SCL_OE;
    endsequence
    AST_RESET_QUIET: assert property ($fell(I_SYS_RST) |->
        !O_REF_POWER_SELECT && !O_CONVERTER_ON && !O_HS_MODE) else $error("outputs active after reset");
    AST_ACK_STANDS: assert property ($rose(O_SDA_OE) |-> s_ack_stands) else $error("data drive too short");
    AST_SDA_ON_LOW_CLOCK: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL, 2))
        else $error("data drive changed with clock high");
    AST_STRETCH_ON_LOW: assert property ($rose(O_SCL_OE) |-> !$past(I_SCL, 2))
        else $error("stretch began with clock high");
    AST_STRETCH_BOUNDED: assert property ($rose(O_SCL_OE) |-> s_stretch_ends)
        else $error("clock stretch never released");
    AST_SINGLE_NO_NEG: assert property (O_INPUT_TYPE_SELECT |-> O_NEG_INPUT_SEL == 8'h00)
        else $error("negative leg used in single-ended mode");
    AST_PAIR_LEGS: assert property (!O_INPUT_TYPE_SELECT && O_POS_INPUT_SEL != 8'h00 |->
        legs inside {8'h03, 8'h0C, 8'h30, 8'hC0}) else $error("differential legs not a pair");
    AST_SAR_MSB_FIRST: assert property ($rose(O_DAC_TRIAL[7]) && O_DAC_TRIAL[6:0] == 7'h00 |=>
        O_DAC_TRIAL[6]) else $error("second trial bit not tried next");
    AST_HS_ENDS_CLOCK_HIGH: assert property ($fell(O_HS_MODE) |-> $past(I_SCL, 3))
        else $error("high-speed left without stop");
endmodule

bind adc_i2c_command_control adc_chk i_adc_chk (
    .I_SYS_CLK           (I_SYS_CLK),
    .I_SYS_RST           (I_SYS_RST),
    .I_SCL               (I_SCL),
    .O_SDA_OE            (O_SDA_OE),
    .O_SCL_OE            (O_SCL_OE),
    .O_INPUT_TYPE_SELECT (O_INPUT_TYPE_SELECT),
    .O_POS_INPUT_SEL     (O_POS_INPUT_SEL),
    .O_NEG_INPUT_SEL     (O_NEG_INPUT_SEL),
    .O_REF_POWER_SELECT  (O_REF_POWER_SELECT),
    .O_CONVERTER_ON      (O_CONVERTER_ON),
    .O_DAC_TRIAL         (O_DAC_TRIAL),
    .O_HS_MODE           (O_HS_MODE)
);

//--- dv/adc_bus_master.sv
// two-wire bus master model pulling open-drain lines from the system clock
module adc_bus_master (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // release clock, then sit out any stretch by the device
    task automatic rise();
        int n;
        n = 0;
        o_scl_low <= 1'b0;
        tick(1);
        while (!i_scl && n < 200) begin
            tick(1);
            n++;
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        o_sda_low <= !b;
        tick(3);
        rise();
        tick(1);
        r = i_sda;
        tick(1);
        o_scl_low <= 1'b1;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic nrx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(nine, nrx);
    endtask
    task automatic start();
        tick(2);
        o_sda_low <= 1'b0;
        tick(3);
        rise();
        tick(2);
        o_sda_low <= 1'b1;
        tick(2);
        o_scl_low <= 1'b1;
    endtask
    task automatic stop();
        tick(2);
        o_sda_low <= 1'b1;
        tick(3);
        rise();
        tick(2);
        o_sda_low <= 1'b0;
        tick(4);
    endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the two-wire converter command block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = 7'h49;
    logic       clk;
    logic       rst;
    logic       pin_lo;
    logic       pin_hi;
    logic [7:0] ain;
    logic       m_scl_low;
    logic       m_sda_low;
    logic       sda_oe;
    logic       scl_oe;
    logic       type_sel;
    logic [2:0] chan;
    logic [7:0] pos;
    logic [7:0] neg;
    logic       shared;
    logic       ref_sel;
    logic       conv_sel;
    logic       conv_on;
    logic [7:0] trial;
    logic       hs;
    logic [7:0] rx;
    logic       nrx;
    logic [7:0] cmd;
    logic [7:0] ep;
    logic [7:0] en;
    int         fail_count;
    int         total_checks;
    // pull-ups on both lines; analog input sits half a step above ain
    wire        scl = !(m_scl_low || scl_oe);
    wire        sda = !(m_sda_low || sda_oe);
    wire        cmp = (trial <= ain);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    adc_i2c_command_control i_adc_i2c_command_control (
        .I_SYS_CLK                (clk),
        .I_SYS_RST                (rst),
        .I_SCL                    (scl),
        .I_SDA                    (sda),
        .I_ADDRESS_PIN_LOW        (pin_lo),
        .I_ADDRESS_PIN_HIGH       (pin_hi),
        .I_CMP                    (cmp),
        .O_SDA_OE                 (sda_oe),
        .O_SDA                    (),
        .O_SCL_OE                 (scl_oe),
        .O_SCL                    (),
        .O_INPUT_TYPE_SELECT      (type_sel),
        .O_CHANNEL_SELECT_BITS    (chan),
        .O_POS_INPUT_SEL          (pos),
        .O_NEG_INPUT_SEL          (neg),
        .O_NEG_IS_SHARED          (shared),
        .O_REF_POWER_SELECT       (ref_sel),
        .O_CONVERTER_POWER_SELECT (conv_sel),
        .O_CONVERTER_ON           (conv_on),
        .O_DAC_TRIAL              (trial),
        .O_HS_MODE                (hs)
    );
    adc_bus_master i_adc_bus_master (
        .i_clk     (clk),
        .i_scl     (scl),
        .i_sda     (sda),
        .o_scl_low (m_scl_low),
        .o_sda_low (m_sda_low)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] tx, input logic nine);
        i_adc_bus_master.byte_io(tx, nine, rx, nrx);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        fail_count++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        pin_lo = 1'b1;
        pin_hi = 1'b0;
        ain = 8'h00;
        fail_count = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("ref_sel", 8'h00, 8'(ref_sel));
        chk("conv_on", 8'h00, 8'(conv_on));
        i_adc_bus_master.start();
        xfer({7'h4A, 1'b0}, 1'b1);
        chk("stranger_ack", 8'h01, 8'(nrx));
        i_adc_bus_master.stop();
        // every type, channel and power code; ignored low bits set
        for (int i = 0; i < 16; i++) begin
            cmd = {i[3:0], i[1:0], 2'b11};
            ain <= 8'(i * 37 + 5);
            i_adc_bus_master.start();
            xfer({DEV, 1'b0}, 1'b1);
            chk("addr_ack", 8'h00, 8'(nrx));
            xfer(cmd, 1'b1);
            chk("cmd_ack", 8'h00, 8'(nrx));
            i_adc_bus_master.stop();
            ep = 8'h01 << {cmd[5:4], cmd[6]};
            en = cmd[7] ? 8'h00 : 8'h01 << {cmd[5:4], !cmd[6]};
            chk("type", 8'(cmd[7]), 8'(type_sel));
            chk("chan", 8'(cmd[6:4]), 8'(chan));
            chk("power", 8'(cmd[3:2]), 8'({ref_sel, conv_sel}));
            chk("pos", ep, pos);
            chk("neg", en, neg);
            chk("shared", 8'(cmd[7]), 8'(shared));
            repeat (20) @(posedge clk);
            i_adc_bus_master.start();
            xfer({DEV, 1'b1}, 1'b1);
            chk("rd_ack", 8'h00, 8'(nrx));
            xfer(8'hFF, 1'b0);
            chk("result", ain, rx);
            xfer(8'hFF, 1'b1);
            chk("result_again", ain, rx);
            i_adc_bus_master.stop();
        end
        ain <= 8'h5A;
        i_adc_bus_master.start();
        xfer(8'h0B, 1'b1);
        chk("hs_code_ack", 8'h01, 8'(nrx));
        i_adc_bus_master.start();
        xfer({DEV, 1'b0}, 1'b1);
        xfer(8'hBC, 1'b1);
        chk("hs_cmd_ack", 8'h00, 8'(nrx));
        i_adc_bus_master.start();
        xfer({DEV, 1'b1}, 1'b1);
        chk("hs_mode", 8'h01, 8'(hs));
        xfer(8'hFF, 1'b1);
        chk("hs_result", 8'h5A, rx);
        i_adc_bus_master.start();
        chk("hs_kept", 8'h01, 8'(hs));
        xfer({DEV, 1'b1}, 1'b1);
        xfer(8'hFF, 1'b1);
        chk("hs_again", 8'h5A, rx);
        i_adc_bus_master.stop();
        repeat (8) @(posedge clk);
        chk("hs_left", 8'h00, 8'(hs));
        end_sim();
    end
endmodule
